// >>> common/vpdd_pkg.sv
// Constants and types shared by the packet dispatch and decode stage.
// Assumes an upstream fetch unit supplying aligned 256-bit packets and APB register access.
package vpdd_pkg;
  localparam int unsigned SLOTS = 8;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned FP_W = 256;
  localparam int unsigned SLOT_ADDR_LO = 2;
  localparam int unsigned SLOT_ADDR_HI = 4;
  // Instruction fields.
  localparam int unsigned CHAIN_BIT = 0;
  localparam int unsigned SIDE_BIT = 1;
  localparam int unsigned DSEL_BIT = 7;
  localparam int unsigned CROSS_BIT = 12;
  localparam int unsigned ZTEST_BIT = 28;
  localparam int unsigned COND_LO = 29;
  localparam int unsigned COND_HI = 31;
  localparam int unsigned OFS_LO = 8;
  localparam int unsigned OFS_HI = 22;
  // Store encodings of the 3-bit load/store opfield, one bit per code.
  localparam logic [7:0] STORE_CODES = 8'hA8;
  // Delay slots per instruction class.
  localparam logic [2:0] DLY_SINGLE = 3'h0;
  localparam logic [2:0] DLY_MPY = 3'h1;
  localparam logic [2:0] DLY_LOAD = 3'h4;
  localparam logic [2:0] DLY_BRANCH = 3'h5;
  // Register map (byte addresses).
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_OPA = 8'h0C;
  localparam logic [7:0] ADDR_OPB = 8'h10;
  localparam logic [7:0] ADDR_FOPCTL = 8'h14;
  localparam logic [7:0] ADDR_FRES = 8'h18;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned FOP_OP_LO = 0;
  localparam int unsigned FOP_P1_LO = 8;
  localparam int unsigned FOP_P2_LO = 16;
  typedef enum logic [1:0] {UNIT_L, UNIT_M, UNIT_S, UNIT_D} vpdd_unit_t;
  typedef enum logic [2:0] {FOP_SATURATING_ADD, FOP_SATURATING_SUBTRACT, FOP_EXT, FOP_EXTU, FOP_CLEAR, FOP_SET} vpdd_fop_t;
endpackage

// >>> design/vpdd_dispatch_decode.sv
// Dispatch and decode stage: splits fetch packets into execute packets and decodes each slot.
// Assumes the fetch unit and condition flags share i_sys_clk, and functional units take a packet every cycle.
`timescale 1ns/1ps
// Overview of operation
// - Fetch packets are eight 32-bit words starting on 256-bit aligned addresses.
// - Slot n sits at byte-address low bits 4*n, first to eighth.
// - Chain bits are scanned from lowest address to highest.
// - Bit 0 set joins the next instruction to this cycle, clear defers it.
// - Each chained group issues together as one execute packet of one to eight.
// - Execute packets never cross the fetch packet; the eighth chain bit reads clear.
// - Delay slots: zero single-cycle, store, nop; one multiply; four load; five branch.
// - Every unit accepts a new instruction each cycle.
// - Loads write data four cycles after first execute, on a separate write port.
// - Branches take effect five cycles later; displacement branches read no registers.
// - Top three bits select the condition register, then a zero/nonzero selector.
// - Side bit picks destination file A or B; cross bit takes source two opposite.
// - Opfield position and width depend on unit format.
// - Multiplies go to the multiplier; compare, detect, normalize, saturate to logic unit.
// - Branch, moves, constants, field ops, shifts to branch unit; memory ops to memory unit.
// - Load/store long format carries an unsigned 15-bit offset.
// - Saturating add and subtract clamp to result width on overflow.
// - Field extract shifts left then right, sign-extending or zero-filling.
// - Field clear and set force bits begin..end to zero or one.
// - Selector one executes on zero register, zero on nonzero; all-zero field always.
// - The condition register is sampled at the first execute phase.
// - A branch target mid-packet discards instructions at lower addresses.
module vpdd_dispatch_decode (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Fetch side.
  input wire logic i_fp_valid,
  input wire logic [vpdd_pkg::FP_W-1:0] i_fp_data,
  input wire logic [31:0] i_fp_addr,
  output logic o_fp_ready,
  // Condition register nonzero flags: B0, B1, B2, A1, A2.
  input wire logic [4:0] i_cond_nz,
  // Execute packet to the functional units.
  output logic o_ep_valid,
  output logic [7:0] o_ep_mask,
  output logic [15:0] o_ep_unit,
  output logic [7:0] o_ep_side,
  output logic [7:0] o_ep_cross,
  output logic [7:0] o_ep_dsel,
  output logic [7:0] o_ep_exec,
  output logic [7:0] o_ep_noread,
  output logic [23:0] o_ep_delay,
  output logic [55:0] o_ep_opfield,
  output logic [119:0] o_ep_ofs,
  // APB slave.
  input wire logic [7:0] i_paddr,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  import vpdd_pkg::*;

  typedef enum logic {DISP_IDLE, DISP_ISSUE} vpdd_state_t;

  function automatic logic [1:0] unit_of(input logic [31:0] w);
    logic [1:0] u;
    u = UNIT_S;
    if (w[3:2] == 2'h3 || w[3:2] == 2'h1) begin
      u = UNIT_D;
    end else if (w[4:2] == 3'h6) begin
      u = UNIT_L;
    end else if (w[3:2] == 2'h2) begin
      u = UNIT_S;
    end else if (w[6:4] == 3'h0) begin
      u = UNIT_M;
    end else if (w[6:4] == 3'h4) begin
      u = UNIT_D;
    end
    return u;
  endfunction

  function automatic logic is_ldst(input logic [31:0] w);
    return w[2] == 1'b1 && w[3:2] != 2'h2 && w[4:2] != 3'h6 || w[3:2] == 2'h3;
  endfunction

  function automatic logic is_nop(input logic [31:0] w);
    return w[17] == 1'b0 && w[12:1] == 12'h000;
  endfunction

  function automatic logic is_bdisp(input logic [31:0] w);
    return w[6:2] == 5'h04;
  endfunction

  function automatic logic [2:0] delay_of(input logic [31:0] w);
    logic [2:0] d;
    d = DLY_SINGLE;
    if (is_nop(w)) begin
      d = DLY_SINGLE;
    end else if (is_bdisp(w)) begin
      d = DLY_BRANCH;
    end else if (unit_of(w) == UNIT_M) begin
      d = DLY_MPY;
    end else if (is_ldst(w) && !STORE_CODES[w[6:4]]) begin
      d = DLY_LOAD;
    end
    return d;
  endfunction

  function automatic logic [6:0] opfield_of(input logic [31:0] w);
    logic [6:0] f;
    case (unit_of(w))
      UNIT_L: f = w[11:5];
      UNIT_M: f = {2'h0, w[11:7]};
      UNIT_S: f = {1'h0, w[11:6]};
      default: f = is_ldst(w) ? {4'h0, w[6:4]} : {1'h0, w[12:7]};
    endcase
    return f;
  endfunction

  function automatic logic cond_ok(input logic [31:0] w, input logic [4:0] nz);
    logic [2:0] c;
    logic r;
    c = w[COND_HI:COND_LO];
    r = 1'b0;
    if (c == 3'h0) begin
      r = !w[ZTEST_BIT];
    end else if (c <= 3'h5) begin
      r = w[ZTEST_BIT] ? !nz[c - 3'h1] : nz[c - 3'h1];
    end
    return r;
  endfunction

  // Lowest pending slot and all chained successors; slot seven never chains on.
  function automatic logic [7:0] ep_mask(input logic [7:0] pb, input logic [7:0] pend);
    logic [7:0] m;
    logic open;
    m = 8'h00;
    open = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (pend[i] && open) begin
        m[i] = 1'b1;
        open = (i < 7) && pb[i];
      end else if (m != 8'h00) begin
        open = 1'b0;
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] fop(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
                                      input logic [4:0] p1, input logic [4:0] p2);
    logic [32:0] s;
    logic [32:0] m;
    logic [31:0] r;
    s = 33'h0_0000_0000;
    m = 33'h0_0000_0000;
    r = a;
    if (p2 >= p1) begin
      m = (33'h0_0000_0002 << p2) - (33'h0_0000_0001 << p1);
    end
    case (op)
      FOP_SATURATING_ADD, FOP_SATURATING_SUBTRACT: begin
        s = (op == FOP_SATURATING_ADD) ? {a[31], a} + {b[31], b} : {a[31], a} - {b[31], b};
        if (s[32] != s[31]) begin
          r = s[32] ? 32'h8000_0000 : 32'h7FFF_FFFF;
        end else begin
          r = s[31:0];
        end
      end
      FOP_EXT: r = 32'($signed(a << p1) >>> p2);
      FOP_EXTU: r = (a << p1) >> p2;
      FOP_CLEAR: r = a & ~m[31:0];
      FOP_SET: r = a | m[31:0];
      default: r = a;
    endcase
    return r;
  endfunction

  vpdd_state_t state_reg;
  logic [FP_W-1:0] pkt_reg;
  logic [7:0] pend_reg;
  logic [7:0] pbits;
  logic [7:0] cur_mask;
  logic [7:0] pend_next;
  logic accept;
  logic [31:0] ctrl_reg;
  logic [31:0] count_reg;
  logic [31:0] opa_reg;
  logic [31:0] opb_reg;
  logic [31:0] fopctl_reg;
  logic [31:0] fres_reg;
  logic [7:0] ep_pbits_reg;
  logic [7:0] ep_uncond_reg;
  logic [7:0] ep_pend_reg;
  logic apb_go;
  logic addr_ok;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pbits[i] = pkt_reg[i*WORD_W + CHAIN_BIT];
    end
  end
  assign cur_mask = ep_mask(pbits, pend_reg);
  assign pend_next = pend_reg & ~cur_mask;
  assign accept = i_fp_valid && o_fp_ready;

  // Dispatch sequencing: one execute packet per cycle until the fetch packet drains.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_reg <= DISP_IDLE;
      pend_reg <= 8'h00;
      pkt_reg <= '0;
      o_fp_ready <= 1'b0;
    end else begin
      case (state_reg)
        DISP_IDLE: begin
          o_fp_ready <= ctrl_reg[CTRL_EN_BIT] && !accept;
          if (accept) begin
            pkt_reg <= i_fp_data;
            pend_reg <= 8'hFF << i_fp_addr[SLOT_ADDR_HI:SLOT_ADDR_LO];
            state_reg <= DISP_ISSUE;
          end
        end
        DISP_ISSUE: begin
          pend_reg <= pend_next;
          if (pend_next == 8'h00) begin
            state_reg <= DISP_IDLE;
            o_fp_ready <= ctrl_reg[CTRL_EN_BIT];
          end
        end
        default: begin
          state_reg <= DISP_IDLE;
          o_fp_ready <= 1'b0;
        end
      endcase
    end
  end

  // Per-slot decode of the packet being issued; condition flags are sampled here, the first execute phase.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_ep_valid <= 1'b0;
      o_ep_mask <= 8'h00;
      o_ep_unit <= 16'h0000;
      o_ep_side <= 8'h00;
      o_ep_cross <= 8'h00;
      o_ep_dsel <= 8'h00;
      o_ep_exec <= 8'h00;
      o_ep_noread <= 8'h00;
      o_ep_delay <= 24'h00_0000;
      o_ep_opfield <= '0;
      o_ep_ofs <= '0;
      ep_pbits_reg <= 8'h00;
      ep_uncond_reg <= 8'h00;
      ep_pend_reg <= 8'h00;
    end else begin
      o_ep_valid <= (state_reg == DISP_ISSUE);
      o_ep_mask <= (state_reg == DISP_ISSUE) ? cur_mask : 8'h00;
      ep_pbits_reg <= pbits;
      ep_pend_reg <= pend_reg;
      for (int i = 0; i < 8; i++) begin
        logic [31:0] w;
        w = pkt_reg[i*WORD_W +: WORD_W];
        o_ep_unit[2*i +: 2] <= unit_of(w);
        o_ep_side[i] <= w[SIDE_BIT];
        o_ep_cross[i] <= (unit_of(w) != UNIT_D) && w[CROSS_BIT];
        o_ep_dsel[i] <= is_ldst(w) ? w[DSEL_BIT] : w[SIDE_BIT];
        o_ep_exec[i] <= cond_ok(w, i_cond_nz);
        ep_uncond_reg[i] <= w[COND_HI:ZTEST_BIT] == 4'h0;
        o_ep_noread[i] <= is_bdisp(w);
        o_ep_delay[3*i +: 3] <= delay_of(w);
        o_ep_opfield[7*i +: 7] <= opfield_of(w);
        o_ep_ofs[15*i +: 15] <= (w[3:2] == 2'h3) ? w[OFS_HI:OFS_LO] : 15'h0000;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      count_reg <= 32'h0000_0000;
    end else if (state_reg == DISP_ISSUE) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  // APB slave: one wait state, so pready rises in the second access cycle.
  assign apb_go = i_psel && i_penable && !o_pready;
  assign addr_ok = i_paddr <= ADDR_FRES && i_paddr[1:0] == 2'h0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= apb_go;
      o_pslverr <= apb_go && !addr_ok;
      o_prdata <= 32'h0000_0000;
      if (apb_go && !i_pwrite) begin
        case (i_paddr)
          ADDR_CTRL: o_prdata <= ctrl_reg;
          ADDR_STATUS: o_prdata <= {16'h0000, pend_reg, 7'h00, state_reg == DISP_ISSUE};
          ADDR_COUNT: o_prdata <= count_reg;
          ADDR_OPA: o_prdata <= opa_reg;
          ADDR_OPB: o_prdata <= opb_reg;
          ADDR_FOPCTL: o_prdata <= fopctl_reg;
          ADDR_FRES: o_prdata <= fres_reg;
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writes land at the edge where pready is sampled high.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ctrl_reg <= CTRL_RST;
      opa_reg <= 32'h0000_0000;
      opb_reg <= 32'h0000_0000;
      fopctl_reg <= 32'h0000_0000;
    end else if (i_psel && i_penable && o_pready && i_pwrite) begin
      case (i_paddr)
        ADDR_CTRL: ctrl_reg <= i_pwdata & CTRL_RST;
        ADDR_OPA: opa_reg <= i_pwdata;
        ADDR_OPB: opb_reg <= i_pwdata;
        ADDR_FOPCTL: fopctl_reg <= i_pwdata & 32'h001F_1F07;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // The field unit result follows its operands one cycle later.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      fres_reg <= 32'h0000_0000;
    end else begin
      fres_reg <= fop(fopctl_reg[FOP_OP_LO +: 3], opa_reg, opb_reg,
                      fopctl_reg[FOP_P1_LO +: 5], fopctl_reg[FOP_P2_LO +: 5]);
    end
  end

  sequence s_accept;
    accept;
  endsequence

  sequence s_issue_starts;
    o_ep_valid && o_ep_mask != 8'h00;
  endsequence

  property p_accept_issues;
    @(posedge i_sys_clk) disable iff (!i_rst_b) s_accept |-> ##2 s_issue_starts;
  endproperty
  a_accept_issues: assert property (p_accept_issues) else $error("Accepted packet did not issue.");

  property p_first_slot;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      accept |-> ##2 o_ep_mask[$past(i_fp_addr[4:2], 2)] && (o_ep_mask & ((8'h01 << $past(i_fp_addr[4:2], 2)) - 8'h01)) == 8'h00;
  endproperty
  a_first_slot: assert property (p_first_slot) else $error("First issued slot does not match the target slot.");

  logic chain_ok;
  always_comb begin
    chain_ok = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (o_ep_mask[i] && o_ep_mask[i+1] && !ep_pbits_reg[i]) begin
        chain_ok = 1'b0;
      end
      if (o_ep_mask[i] && !o_ep_mask[i+1] && ep_pbits_reg[i] && o_ep_mask != 8'h00 && i < 7 && ep_pend_reg[i+1]) begin
        chain_ok = 1'b0;
      end
    end
  end

  property p_chain;
    @(posedge i_sys_clk) disable iff (!i_rst_b) o_ep_valid |-> chain_ok;
  endproperty
  a_chain: assert property (p_chain) else $error("Execute packet does not follow the chain bits.");

  property p_one_per_cycle;
    @(posedge i_sys_clk) disable iff (!i_rst_b) o_ep_valid ##1 o_ep_valid |-> (o_ep_mask & $past(o_ep_mask)) == 8'h00;
  endproperty
  a_one_per_cycle: assert property (p_one_per_cycle) else $error("A slot issued twice.");

  property p_busy_blocks_fetch;
    @(posedge i_sys_clk) disable iff (!i_rst_b) accept |=> !o_fp_ready;
  endproperty
  a_busy_blocks_fetch: assert property (p_busy_blocks_fetch) else $error("Fetch ready while a packet is held.");

  // Every issued displacement branch must carry the branch delay and sit on the branch unit, in any slot.
  logic br_ok;
  always_comb begin
    br_ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (o_ep_mask[i] && o_ep_noread[i] &&
          (o_ep_delay[3*i +: 3] != DLY_BRANCH || o_ep_unit[2*i +: 2] != UNIT_S)) begin
        br_ok = 1'b0;
      end
    end
  end

  property p_branch_delay;
    @(posedge i_sys_clk) disable iff (!i_rst_b) o_ep_valid |-> br_ok;
  endproperty
  a_branch_delay: assert property (p_branch_delay) else $error("Branch delay or unit wrong.");

  property p_uncond_exec;
    @(posedge i_sys_clk) disable iff (!i_rst_b) o_ep_valid && ep_uncond_reg[0] |-> o_ep_exec[0];
  endproperty
  a_uncond_exec: assert property (p_uncond_exec) else $error("Unconditional slot was not executed.");

  property p_apb_answer;
    @(posedge i_sys_clk) disable iff (!i_rst_b) i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer timing wrong.");

  property p_count;
    @(posedge i_sys_clk) disable iff (!i_rst_b) state_reg == DISP_ISSUE |=> count_reg == $past(count_reg) + 32'h0000_0001;
  endproperty
  a_count: assert property (p_count) else $error("Issue count did not advance.");
endmodule

// >>> verification/test_vpdd_dispatch_decode.sv
// Self-checking bench for the dispatch and decode stage.
// Assumes the fetch model drives the fetch port and the bench acts as APB master.
`timescale 1ns/1ps
module test_vpdd_dispatch_decode;
  import vpdd_pkg::*;
  logic i_sys_clk, i_rst_b, i_fp_valid, o_fp_ready, o_ep_valid;
  logic [FP_W-1:0] i_fp_data;
  logic [31:0] i_fp_addr, i_pwdata, o_prdata;
  logic [4:0] i_cond_nz;
  logic [7:0] o_ep_mask, o_ep_side, o_ep_cross, o_ep_dsel, o_ep_exec, o_ep_noread, i_paddr;
  logic [15:0] o_ep_unit;
  logic [23:0] o_ep_delay;
  logic [55:0] o_ep_opfield;
  logic [119:0] o_ep_ofs;
  logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  int error_cnt = 0;
  int checks = 0;

  vpdd_dispatch_decode uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_fp_valid(i_fp_valid),
    .i_fp_data(i_fp_data), .i_fp_addr(i_fp_addr), .o_fp_ready(o_fp_ready), .i_cond_nz(i_cond_nz),
    .o_ep_valid(o_ep_valid), .o_ep_mask(o_ep_mask), .o_ep_unit(o_ep_unit), .o_ep_side(o_ep_side),
    .o_ep_cross(o_ep_cross), .o_ep_dsel(o_ep_dsel), .o_ep_exec(o_ep_exec), .o_ep_noread(o_ep_noread),
    .o_ep_delay(o_ep_delay), .o_ep_opfield(o_ep_opfield), .o_ep_ofs(o_ep_ofs), .i_paddr(i_paddr),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));
  vpdd_fetch_model fetch (.i_clk(i_sys_clk), .i_fp_ready(o_fp_ready), .o_fp_valid(i_fp_valid),
    .o_fp_data(i_fp_data), .o_fp_addr(i_fp_addr));

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic finish_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int t;
    t = 0;
    i_psel <= 1'b1;
    i_paddr <= a;
    i_pwrite <= wr;
    i_pwdata <= wd;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1 && t < 50) begin
      @(posedge i_sys_clk);
      t++;
    end
    if (t >= 50) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, o_pready, 1'b1);
    end
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  function automatic logic [FP_W-1:0] pk(input logic [7:0] p);
    logic [FP_W-1:0] d;
    d = '0;
    for (int n = 0; n < 8; n++) d[32*n] = p[n];
    return d;
  endfunction

  task automatic wait_ep();
    int t;
    t = 0;
    while (o_ep_valid !== 1'b1 && t < 50) begin
      @(posedge i_sys_clk);
      #1;
      t++;
    end
    if (t >= 50) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, o_ep_valid, 1'b1);
    end
  endtask

  // Masks are packed lowest byte first, one per consecutive issue cycle.
  task automatic expect_eps(input logic [63:0] m, input int n);
    wait_ep();
    for (int k = 0; k < n; k++) begin
      cmp(o_ep_mask, m[8*k +: 8]);
      @(posedge i_sys_clk);
      #1;
    end
    cmp(o_ep_valid, 1'b0);
  endtask

  task automatic t_reset();
    repeat (9) @(posedge i_sys_clk);
    #1;
    cmp(o_fp_ready, 1'b0);
    cmp(o_ep_valid, 1'b0);
    @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    cmp(o_fp_ready, 1'b1);
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic err;
    @(posedge i_sys_clk);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
    cmp({err, rd}, {1'b0, CTRL_RST});
    apb(1'b1, 8'h40, 32'hFFFF_FFFF, rd, err);
    cmp(err, 1'b1);
    apb(1'b0, 8'h42, 32'h0, rd, err);
    cmp({err, rd}, {1'b1, 32'h0});
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, rd, err);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
    cmp(rd, 32'h0);
  endtask

  task automatic t_chain();
    @(posedge i_sys_clk);
    fetch.send(pk(8'hEC), 32'h0000_0100);
    expect_eps(64'hE01C_0201, 4);
    @(posedge i_sys_clk);
    fetch.send(pk(8'hFF), 32'h0000_0120);
    expect_eps(64'hFF, 1);
    @(posedge i_sys_clk);
    fetch.send(pk(8'h00), 32'h0000_0140);
    expect_eps(64'h8040_2010_0804_0201, 8);
  endtask

  task automatic t_branch();
    @(posedge i_sys_clk);
    fetch.send(pk(8'hEC), 32'h0000_010E);
    expect_eps(64'hE018, 2);
  endtask

  // Slots use L, M, S, D, D, S, D and a no-op; slots 2 and 5 both use S on side A, slots 3 and 4 both use D on side A.
  task automatic t_decode();
    logic [FP_W-1:0] d;
    d = {32'h0, 32'h0000_0043, 32'h9000_0011, 32'h1000_003D,
         32'hC05A_5AAD, 32'h3000_0009, 32'h2000_0981, 32'h0000_14BB};
    @(posedge i_sys_clk);
    fetch.send(d, 32'h0000_0200);
    wait_ep();
    cmp(o_ep_mask, 8'hFF);
    cmp(o_ep_unit[13:0], 14'h3BE4);
    cmp(o_ep_exec, 8'hE3);
    cmp(o_ep_side, 8'h41);
    cmp(o_ep_cross, 8'h01);
    cmp(o_ep_dsel, 8'h49);
    cmp(o_ep_noread, 8'h20);
    cmp(o_ep_delay, 24'h02_8808);
    cmp(o_ep_opfield, 56'h00_0000_3040_09A5);
    cmp(o_ep_ofs, {105'h0, 15'h5A5A} << 45);
    // Same packet with B0 zero and the other condition registers nonzero.
    @(posedge i_sys_clk);
    i_cond_nz <= 5'h1E;
    fetch.send(d, 32'h0000_0220);
    wait_ep();
    cmp(o_ep_exec, 8'hC5);
  endtask

  task automatic t_refuse();
    logic [31:0] rd;
    logic err;
    @(posedge i_sys_clk);
    apb(1'b1, ADDR_CTRL, 32'h0, rd, err);
    repeat (2) @(posedge i_sys_clk);
    fork
      begin
        fetch.send(pk(8'hFF), 32'h0000_0300);
        expect_eps(64'hFF, 1);
      end
      begin
        repeat (6) begin
          @(posedge i_sys_clk);
          #1;
          cmp({o_fp_ready, o_ep_valid}, 2'b00);
        end
        @(posedge i_sys_clk);
        apb(1'b1, ADDR_CTRL, 32'h1, rd, err);
      end
    join
  endtask

  task automatic t_field();
    logic [31:0] ta [6] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h0000_F000, 32'h0000_F000, 32'hFFFF_FFFF, 32'h0};
    logic [31:0] tc [6] = '{32'h0000_0000, 32'h0000_0001, 32'h001C_1002, 32'h001C_1003, 32'h0007_0404,
                            32'h000B_0805};
    logic [31:0] te [6] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_000F, 32'hFFFF_FF0F,
                            32'h0000_0F00};
    logic [31:0] rd;
    logic err;
    @(posedge i_sys_clk);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, ADDR_OPA, ta[k], rd, err);
      apb(1'b1, ADDR_OPB, 32'h0000_0001, rd, err);
      apb(1'b1, ADDR_FOPCTL, tc[k], rd, err);
      apb(1'b0, ADDR_FRES, 32'h0, rd, err);
      cmp(rd, te[k]);
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    i_rst_b = 1'b0;
    i_cond_nz = 5'h01;
    i_paddr = '0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_pwdata = '0;
    t_reset();
    t_regs();
    t_chain();
    t_branch();
    t_decode();
    t_refuse();
    t_field();
    finish_test();
  end
endmodule

// >>> verification/vpdd_fetch_model.sv
// Behavioural fetch unit that offers one fetch packet at a time to the dispatch stage.
// Assumes the caller starts a request just after a rising edge of i_clk.
`timescale 1ns/1ps
module vpdd_fetch_model (
  // Clock.
  input wire logic i_clk,
  // Fetch handshake.
  input wire logic i_fp_ready,
  output logic o_fp_valid,
  output logic [vpdd_pkg::FP_W-1:0] o_fp_data,
  output logic [31:0] o_fp_addr
);
  import vpdd_pkg::*;
  initial begin
    o_fp_valid = 1'b0;
    o_fp_data = '0;
    o_fp_addr = '0;
  end
  // After the take the bus shows the inverse, so a stale packet can never pass for a fresh one.
  task automatic send(input logic [FP_W-1:0] d, input logic [31:0] a);
    int t;
    t = 0;
    o_fp_valid <= 1'b1;
    o_fp_data <= d;
    o_fp_addr <= a;
    @(posedge i_clk);
    while (i_fp_ready !== 1'b1 && t < 200) begin
      @(posedge i_clk);
      t++;
    end
    o_fp_valid <= 1'b0;
    o_fp_data <= ~d;
    o_fp_addr <= ~a;
  endtask
endmodule
